/* hw/usb_ep_dev.sv */
// Endpoint buffers, byte counts and flags behind an indirect port.
// Assumes the engine side and the controller share mclk.
// Function
// - Endpoint 0 shares one 64-byte buffer
// - Load IN data first; counts 0 to 64
// - Endpoint 0 count write arms IN
// - Good OUT0: ACK, count, flag, interrupt
// - Bytes stored; count and ACK after check
// - Good OUT1: count, flag, interrupt
// - Endpoint 2 count write records and arms
// - Endpoint 3 count write records and arms
// - Count bit 7 reads zero
// - Buffers not reset, survive other resets
// - CPU writes bytes then endpoint 0 count
// - Endpoint 1 double 64-byte receive buffer
// - CPU reads count then that many bytes
// - Endpoint 2 double 64-byte transmit buffer
// - Endpoint 3 single 64-byte transmit buffer
// - Setup bytes into 8-byte buffer, flag
// - Five-bit offset decode of counts, ports
// - Read: offset, wait busy, take data
// - Write: offset, data, wait busy
// - IN count write clears buffer-available flag
// - Clearing OUT flag re-arms endpoint
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "usb_ep_cfg.svh"
module usb_ep_dev
   import usb_ep_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Indirect register port
   usb_ep_if.dev cpu,
   // Received packets from the engine
   input wire logic rx_start,
   input wire logic [1:0] rx_ep,
   input wire logic rx_setup,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_ok,
   input wire logic rx_err,
   // IN requests and the host acknowledge
   input wire logic in_req,
   input wire logic [1:0] in_ep,
   input wire logic in_ack,
   // Answers to the engine, and the interrupt
   output logic hs_ack,
   output logic hs_nak,
   output logic tx_valid,
   output logic [7:0] tx_data,
   output logic tx_eop,
   output logic usb_irq
);
   ix_state_t st_ff;
   rx_kind_t rx_kind_ff;
   tx_state_t tx_st_ff;
   logic [4:0] addr_ff;
   logic rnw_ff;
   logic [7:0] wdata_ff, rdata_ff, rd_mux, tx_byte;
   logic [1:0] wait_ff, irq_en_ff, full1_ff, full2_ff, tx_ep_ff;
   logic do_acc, cpu_wr, fw;
   logic [7:0] ep0_mem [0:63];
   logic [7:0] ep1_mem [0:127];
   logic [7:0] ep2_mem [0:127];
   logic [7:0] ep3_mem [0:63];
   logic [7:0] su_mem [0:7];
   logic [6:0] cnt0_ff, cnt3_ff, rx_cnt_ff, tx_cnt_ff, tx_ptr_ff, rx_lim;
   logic [6:0] cnt1_ff [0:1];
   logic [6:0] cnt2_ff [0:1];
   logic s1_ff, c1_ff, s2_ff, c2_ff, arm0_ff, arm3_ff;
   logic ctrl_in_buffer_available_ff, ctrl_out_data_available_ff;
   logic in2_buffer_available_ff, in3_buffer_available_ff;
   logic setup_data_available_ff, out1_data_available;
   logic rx_on_ff, rx_acc_ff, rx_wr, commit, reject, in_nak, in_done;
   logic armed_sel, out1_clr;
   logic [6:0] cnt_sel;
   logic [5:0] p0_ff, p1_ff, p2_ff, p3_ff;
   logic [2:0] ps_ff;
   logic wr_bc0, wr_bc2, wr_bc3;
   logic hs_ack_ff, hs_nak_ff, tx_valid_ff, tx_eop_ff, usb_irq_ff;
   logic [7:0] tx_data_ff;

   // Indirect access carried out once the busy count has run down
   assign do_acc = (st_ff == IX_WORK) && (wait_ff == 2'h0);
   assign cpu_wr = do_acc && !rnw_ff;
   assign fw = cpu_wr && (addr_ff == `OFS_FLAGS);
   assign wr_bc0 = cpu_wr && (addr_ff == `OFS_BC0);
   assign wr_bc2 = cpu_wr && (addr_ff == `OFS_BC2);
   assign wr_bc3 = cpu_wr && (addr_ff == `OFS_BC3);
   assign cpu.ia_busy = (st_ff != IX_IDLE);
   assign cpu.id_rdata = rdata_ff;

   // Indirect sequencer: offset, optional data, then busy
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st_ff <= IX_IDLE;
         addr_ff <= 5'h00;
         rnw_ff <= 1'b0;
         wdata_ff <= 8'h00;
         wait_ff <= 2'h0;
      end else begin
         case (st_ff)
            IX_IDLE: if (cpu.ia_load) begin
               addr_ff <= cpu.ia_addr;
               rnw_ff <= cpu.ia_rnw;
               wait_ff <= `BUSY_CYCLES;
               st_ff <= cpu.ia_rnw ? IX_WORK : IX_WAIT_DATA;
            end
            IX_WAIT_DATA: if (cpu.id_write) begin
               wdata_ff <= cpu.id_wdata;
               st_ff <= IX_WORK;
            end
            IX_WORK: if (wait_ff == 2'h0) begin
               st_ff <= IX_IDLE;
            end else begin
               wait_ff <= wait_ff - 2'h1;
            end
            default: st_ff <= IX_IDLE;
         endcase
      end
   end

   // Offset decode for reads; unmapped offsets read zero
   always_comb begin
      rd_mux = 8'h00;
      case (addr_ff)
         `OFS_IRQ_EN: rd_mux[`FLG_OUT1:`FLG_OUT0] = irq_en_ff;
         `OFS_FLAGS: rd_mux[`FLG_SETUP:`FLG_IN0] = {setup_data_available_ff,
            in3_buffer_available_ff, in2_buffer_available_ff,
            out1_data_available, ctrl_out_data_available_ff,
            ctrl_in_buffer_available_ff};
         `OFS_BC0: rd_mux = {1'b0, cnt0_ff};
         `OFS_BC1: rd_mux = {1'b0, cnt1_ff[c1_ff]};
         `OFS_BC2: rd_mux = {1'b0, cnt2_ff[!c2_ff]};
         `OFS_BC3: rd_mux = {1'b0, cnt3_ff};
         `OFS_DP0: rd_mux = ep0_mem[p0_ff];
         `OFS_DP1: rd_mux = ep1_mem[{c1_ff, p1_ff}];
         `OFS_DP2: rd_mux = ep2_mem[{c2_ff, p2_ff}];
         `OFS_DP3: rd_mux = ep3_mem[p3_ff];
         `OFS_DPS: rd_mux = su_mem[ps_ff];
         default: rd_mux = 8'h00;
      endcase
   end

   // Read result stands in the indirect data register until the next read
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rdata_ff <= 8'h00;
      end else if (do_acc && rnw_ff) begin
         rdata_ff <= rd_mux;
      end
   end

   // Receive path: acceptance is decided once, at the token
   assign rx_lim = (rx_kind_ff == RX_SETUP) ? `SETUP_BYTES : `EP_BYTES;
   assign rx_wr = rx_on_ff && rx_acc_ff && rx_valid && (rx_cnt_ff < rx_lim);
   assign commit = rx_on_ff && rx_ok && rx_acc_ff;
   assign reject = rx_on_ff && rx_ok && !rx_acc_ff;
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rx_on_ff <= 1'b0;
         rx_acc_ff <= 1'b0;
         rx_kind_ff <= RX_EP0;
         rx_cnt_ff <= 7'h00;
      end else if (rx_start) begin
         rx_on_ff <= 1'b1;
         rx_cnt_ff <= 7'h00;
         rx_kind_ff <= rx_setup ? RX_SETUP :
            ((rx_ep == `EP_OUT1) ? RX_EP1 : RX_EP0);
         rx_acc_ff <= rx_setup ||
            ((rx_ep == `EP_CTRL) && !ctrl_out_data_available_ff) ||
            ((rx_ep == `EP_OUT1) && !full1_ff[s1_ff]);
      end else if (rx_ok || rx_err) begin
         rx_on_ff <= 1'b0;
      end else if (rx_wr) begin
         rx_cnt_ff <= rx_cnt_ff + 7'h01;
      end
   end

   // Handshakes: ACK only after an error-free packet
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         hs_ack_ff <= 1'b0;
         hs_nak_ff <= 1'b0;
      end else begin
         hs_ack_ff <= commit;
         hs_nak_ff <= reject || in_nak;
      end
   end
   assign hs_ack = hs_ack_ff;
   assign hs_nak = hs_nak_ff;

   // Endpoint state, counts and flags; a set always beats a clear
   assign out1_data_available = full1_ff[c1_ff];
   assign out1_clr = fw && !wdata_ff[`FLG_OUT1] && full1_ff[c1_ff];
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cnt0_ff <= 7'h00;
         cnt3_ff <= 7'h00;
         cnt1_ff[0] <= 7'h00;
         cnt1_ff[1] <= 7'h00;
         cnt2_ff[0] <= 7'h00;
         cnt2_ff[1] <= 7'h00;
         {arm0_ff, arm3_ff, s1_ff, c1_ff, s2_ff, c2_ff} <= 6'h00;
         full1_ff <= 2'h0;
         full2_ff <= 2'h0;
         irq_en_ff <= 2'h0;
         ctrl_in_buffer_available_ff <= `BAV_RST;
         in2_buffer_available_ff <= `BAV_RST;
         in3_buffer_available_ff <= `BAV_RST;
         ctrl_out_data_available_ff <= 1'b0;
         setup_data_available_ff <= 1'b0;
      end else begin
         if (cpu_wr && (addr_ff == `OFS_IRQ_EN)) begin
            irq_en_ff <= wdata_ff[`FLG_OUT1:`FLG_OUT0];
         end
         if (wr_bc0) begin
            cnt0_ff <= wdata_ff[6:0];
            arm0_ff <= 1'b1;
         end else if (in_done && (tx_ep_ff == `EP_CTRL)) begin
            arm0_ff <= 1'b0;
         end
         if (commit && (rx_kind_ff == RX_EP0)) begin
            cnt0_ff <= rx_cnt_ff;
         end
         ctrl_out_data_available_ff <= (commit && (rx_kind_ff == RX_EP0)) ||
            (ctrl_out_data_available_ff && !(fw && !wdata_ff[`FLG_OUT0]));
         ctrl_in_buffer_available_ff <= (in_done && (tx_ep_ff == `EP_CTRL)) ||
            (ctrl_in_buffer_available_ff && !wr_bc0 &&
            !(fw && !wdata_ff[`FLG_IN0]));
         setup_data_available_ff <= (commit && (rx_kind_ff == RX_SETUP)) ||
            (setup_data_available_ff && !(fw && !wdata_ff[`FLG_SETUP]));
         // Endpoint 1: engine fills one bank while the CPU drains the other
         if (commit && (rx_kind_ff == RX_EP1)) begin
            cnt1_ff[s1_ff] <= rx_cnt_ff;
            full1_ff[s1_ff] <= 1'b1;
            s1_ff <= !s1_ff;
         end
         if (out1_clr) begin
            full1_ff[c1_ff] <= 1'b0;
            c1_ff <= !c1_ff;
         end
         // Endpoint 2: CPU loads one bank while the engine sends the other
         if (in_done && (tx_ep_ff == `EP_IN2)) begin
            full2_ff[s2_ff] <= 1'b0;
            s2_ff <= !s2_ff;
         end
         if (wr_bc2) begin
            cnt2_ff[c2_ff] <= wdata_ff[6:0];
            full2_ff[c2_ff] <= 1'b1;
            c2_ff <= !c2_ff;
         end
         in2_buffer_available_ff <= (in_done && (tx_ep_ff == `EP_IN2)) ||
            (in2_buffer_available_ff && !wr_bc2 &&
            !(fw && !wdata_ff[`FLG_IN2]));
         if (wr_bc3) begin
            cnt3_ff <= wdata_ff[6:0];
            arm3_ff <= 1'b1;
         end else if (in_done && (tx_ep_ff == `EP_IN3)) begin
            arm3_ff <= 1'b0;
         end
         in3_buffer_available_ff <= (in_done && (tx_ep_ff == `EP_IN3)) ||
            (in3_buffer_available_ff && !wr_bc3 &&
            !(fw && !wdata_ff[`FLG_IN3]));
      end
   end

   // Interrupt follows the OUT flags through their enables
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         usb_irq_ff <= 1'b0;
      end else begin
         usb_irq_ff <= (ctrl_out_data_available_ff && irq_en_ff[0]) ||
            (out1_data_available && irq_en_ff[1]);
      end
   end
   assign usb_irq = usb_irq_ff;

   // CPU byte pointers: one step per port access, restart on arm or delivery
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         {p0_ff, p1_ff, p2_ff, p3_ff} <= 24'h000000;
         ps_ff <= 3'h0;
      end else begin
         if (wr_bc0 || commit && (rx_kind_ff == RX_EP0) || in_done) begin
            p0_ff <= 6'h00;
         end else if (do_acc && (addr_ff == `OFS_DP0)) begin
            p0_ff <= p0_ff + 6'h01;
         end
         if (out1_clr || commit && (rx_kind_ff == RX_EP1) && s1_ff == c1_ff)
         begin
            p1_ff <= 6'h00;
         end else if (do_acc && (addr_ff == `OFS_DP1)) begin
            p1_ff <= p1_ff + 6'h01;
         end
         if (wr_bc2) begin
            p2_ff <= 6'h00;
         end else if (do_acc && (addr_ff == `OFS_DP2)) begin
            p2_ff <= p2_ff + 6'h01;
         end
         if (wr_bc3) begin
            p3_ff <= 6'h00;
         end else if (do_acc && (addr_ff == `OFS_DP3)) begin
            p3_ff <= p3_ff + 6'h01;
         end
         if (commit && (rx_kind_ff == RX_SETUP)) begin
            ps_ff <= 3'h0;
         end else if (do_acc && (addr_ff == `OFS_DPS)) begin
            ps_ff <= ps_ff + 3'h1;
         end
      end
   end

   // Buffer storage has no reset so contents survive every reset
   always_ff @(posedge mclk) begin
      if (rx_wr && (rx_kind_ff == RX_EP0)) begin
         ep0_mem[rx_cnt_ff[5:0]] <= rx_data;
      end
      if (rx_wr && (rx_kind_ff == RX_EP1)) begin
         ep1_mem[{s1_ff, rx_cnt_ff[5:0]}] <= rx_data;
      end
      if (rx_wr && (rx_kind_ff == RX_SETUP)) begin
         su_mem[rx_cnt_ff[2:0]] <= rx_data;
      end
      if (cpu_wr && (addr_ff == `OFS_DP0)) begin
         ep0_mem[p0_ff] <= wdata_ff;
      end
      if (cpu_wr && (addr_ff == `OFS_DP2)) begin
         ep2_mem[{c2_ff, p2_ff}] <= wdata_ff;
      end
      if (cpu_wr && (addr_ff == `OFS_DP3)) begin
         ep3_mem[p3_ff] <= wdata_ff;
      end
   end

   // IN answer: armed endpoints send data, others NAK
   always_comb begin
      armed_sel = 1'b0;
      cnt_sel = cnt3_ff;
      case (in_ep)
         `EP_CTRL: begin
            armed_sel = arm0_ff;
            cnt_sel = cnt0_ff;
         end
         `EP_IN2: begin
            armed_sel = full2_ff[s2_ff];
            cnt_sel = cnt2_ff[s2_ff];
         end
         `EP_IN3: armed_sel = arm3_ff;
         default: armed_sel = 1'b0;
      endcase
      case (tx_ep_ff)
         `EP_CTRL: tx_byte = ep0_mem[tx_ptr_ff[5:0]];
         `EP_IN2: tx_byte = ep2_mem[{s2_ff, tx_ptr_ff[5:0]}];
         default: tx_byte = ep3_mem[tx_ptr_ff[5:0]];
      endcase
   end
   assign in_nak = in_req && (tx_st_ff != TX_SEND) && !armed_sel;
   assign in_done = (tx_st_ff == TX_DONE) && in_ack;

   // Transmit sequencer; a repeated IN while waiting resends the packet
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         tx_st_ff <= TX_IDLE;
         tx_ep_ff <= 2'h0;
         tx_cnt_ff <= 7'h00;
         tx_ptr_ff <= 7'h00;
         tx_valid_ff <= 1'b0;
         tx_eop_ff <= 1'b0;
         tx_data_ff <= 8'h00;
      end else begin
         tx_valid_ff <= 1'b0;
         tx_eop_ff <= 1'b0;
         case (tx_st_ff)
            TX_IDLE, TX_DONE: if (in_req && armed_sel) begin
               tx_ep_ff <= in_ep;
               tx_cnt_ff <= cnt_sel;
               tx_ptr_ff <= 7'h00;
               tx_st_ff <= TX_SEND;
            end else if (in_done) begin
               tx_st_ff <= TX_IDLE;
            end
            TX_SEND: if (tx_ptr_ff == tx_cnt_ff) begin
               tx_eop_ff <= 1'b1;
               tx_st_ff <= TX_DONE;
            end else begin
               tx_valid_ff <= 1'b1;
               tx_data_ff <= tx_byte;
               tx_ptr_ff <= tx_ptr_ff + 7'h01;
            end
            default: tx_st_ff <= TX_IDLE;
         endcase
      end
   end
   assign tx_valid = tx_valid_ff;
   assign tx_data = tx_data_ff;
   assign tx_eop = tx_eop_ff;
endmodule

/* hw/usb_ep_cfg.svh */
// Offsets, field positions, reset values and timing counts for the
// USB endpoint buffer block and its indirect-access controller.
// Assumes it is included by bare name from every file that needs it.
`ifndef USB_EP_CFG_SVH
`define USB_EP_CFG_SVH

// Indirect offsets inside the endpoint block
`define OFS_IRQ_EN 5'h06
`define OFS_FLAGS 5'h07
`define OFS_BC0 5'h0B
`define OFS_BC1 5'h0C
`define OFS_BC2 5'h0D
`define OFS_BC3 5'h0E
`define OFS_DP0 5'h10
`define OFS_DP1 5'h11
`define OFS_DP2 5'h12
`define OFS_DP3 5'h13
`define OFS_DPS 5'h14

// Bit positions in the flag and interrupt enable registers
`define FLG_IN0 0
`define FLG_OUT0 1
`define FLG_OUT1 2
`define FLG_IN2 3
`define FLG_IN3 4
`define FLG_SETUP 5
`define BAV_RST 1'h1

// Buffer sizes and endpoint numbers
`define EP_BYTES 7'h40
`define SETUP_BYTES 7'h08
`define MAX_COUNT 8'h40
`define EP_CTRL 2'h0
`define EP_OUT1 2'h1
`define EP_IN2 2'h2
`define EP_IN3 2'h3

// Cycles an indirect access stays busy before it is carried out
`define BUSY_CYCLES 2'h2

// Controller register offsets and fields
`define CTL_CMD 2'h0
`define CTL_DATA 2'h1
`define CTL_STAT 2'h2
`define CTL_RESULT 2'h3
`define CMD_RNW 7
`define STAT_BUSY 0
`define STAT_REFUSED 1

`endif

/* hw/usb_ep_pkg.sv */
// State and kind types shared by the endpoint block and its controller.
// Assumes nothing beyond a SystemVerilog compiler.
package usb_ep_pkg;
   typedef enum logic [1:0] {IX_IDLE, IX_WAIT_DATA, IX_WORK} ix_state_t;
   typedef enum logic [1:0] {RX_EP0, RX_EP1, RX_SETUP} rx_kind_t;
   typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_DONE} tx_state_t;
   typedef enum logic [1:0] {C_IDLE, C_LOAD, C_DATA, C_WAIT} ctl_state_t;
endpackage

/* hw/usb_ep_if.sv */
// Indirect register link between the controller and the endpoint block.
// Assumes both ends run on the same mclk.
`timescale 1ns/1ps
interface usb_ep_if;
   logic ia_load;
   logic ia_rnw;
   logic [4:0] ia_addr;
   logic id_write;
   logic [7:0] id_wdata;
   logic [7:0] id_rdata;
   logic ia_busy;
   modport dev(input ia_load, ia_rnw, ia_addr, id_write, id_wdata,
      output id_rdata, ia_busy);
   modport ctl(output ia_load, ia_rnw, ia_addr, id_write, id_wdata,
      input id_rdata, ia_busy);
endinterface

/* hw/usb_ep_ctl.sv */
// Controller end: runs indirect reads and writes for software.
// Assumes a software port on mclk with read data one cycle later.
`timescale 1ns/1ps
`include "usb_ep_cfg.svh"
module usb_ep_ctl
   import usb_ep_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Indirect register link
   usb_ep_if.ctl usb,
   // Software register port
   input wire logic [1:0] sw_addr,
   input wire logic [7:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [7:0] sw_rdata
);
   ctl_state_t st_ff;
   logic [4:0] ofs_ff;
   logic rnw_ff, refused_ff, start, bad_count;
   logic [7:0] dat_ff, result_ff, sw_rdata_ff;

   // IN counts above the buffer size are refused before they leave
   assign bad_count = !sw_wdata[`CMD_RNW] && (dat_ff > `MAX_COUNT) &&
      (sw_wdata[4:0] == `OFS_BC0 || sw_wdata[4:0] == `OFS_BC2 ||
      sw_wdata[4:0] == `OFS_BC3);
   assign start = sw_wr && (sw_addr == `CTL_CMD) && (st_ff == C_IDLE);

   // Command sequencer; commands while busy are dropped
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         st_ff <= C_IDLE;
         ofs_ff <= 5'h00;
         rnw_ff <= 1'b0;
         refused_ff <= 1'b0;
      end else begin
         case (st_ff)
            C_IDLE: if (start) begin
               refused_ff <= bad_count;
               ofs_ff <= sw_wdata[4:0];
               rnw_ff <= sw_wdata[`CMD_RNW];
               if (!bad_count) begin
                  st_ff <= C_LOAD;
               end
            end
            C_LOAD: st_ff <= rnw_ff ? C_WAIT : C_DATA;
            C_DATA: st_ff <= C_WAIT;
            C_WAIT: if (!usb.ia_busy) begin
               st_ff <= C_IDLE;
            end
            default: st_ff <= C_IDLE;
         endcase
      end
   end

   // Write data and the last read result
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         dat_ff <= 8'h00;
         result_ff <= 8'h00;
      end else begin
         if (sw_wr && (sw_addr == `CTL_DATA) && (st_ff == C_IDLE)) begin
            dat_ff <= sw_wdata;
         end
         if ((st_ff == C_WAIT) && !usb.ia_busy && rnw_ff) begin
            result_ff <= usb.id_rdata;
         end
      end
   end

   // Link strobes are single cycles taken from the state
   assign usb.ia_load = (st_ff == C_LOAD);
   assign usb.ia_addr = ofs_ff;
   assign usb.ia_rnw = rnw_ff;
   assign usb.id_write = (st_ff == C_DATA);
   assign usb.id_wdata = dat_ff;

   // Software read data, valid the cycle after the strobe
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         sw_rdata_ff <= 8'h00;
      end else if (sw_rd) begin
         case (sw_addr)
            `CTL_CMD: sw_rdata_ff <= {rnw_ff, 2'h0, ofs_ff};
            `CTL_DATA: sw_rdata_ff <= dat_ff;
            `CTL_STAT: sw_rdata_ff <= {6'h00, refused_ff, st_ff != C_IDLE};
            `CTL_RESULT: sw_rdata_ff <= result_ff;
            default: sw_rdata_ff <= 8'h00;
         endcase
      end
   end
   assign sw_rdata = sw_rdata_ff;
endmodule

/* tb/usb_ep_link_chk.sv */
// Timing checks on the indirect link between controller and endpoint block.
// Assumes both ends run on mclk and the signals arrive as plain inputs.
`timescale 1ns/1ps
`include "usb_ep_cfg.svh"
module usb_ep_link_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Controller to endpoint block
   input wire logic ia_load,
   input wire logic ia_rnw,
   input wire logic [4:0] ia_addr,
   input wire logic id_write,
   input wire logic [7:0] id_wdata,
   // Endpoint block to controller
   input wire logic [7:0] id_rdata,
   input wire logic ia_busy
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Reads whose result, or its top bit, is fixed whatever the buffers hold
   wire cnt_rd = ia_load && ia_rnw && ia_addr >= `OFS_BC0 &&
      ia_addr <= `OFS_BC3;
   wire gap_rd = ia_load && ia_rnw && ia_addr > `OFS_DPS;
   // A load seen while busy would be lost, so the controller must wait
   chk_load_idle: assert property (ia_load |-> !ia_busy)
      else $error("offset loaded while busy");
   chk_busy_rise: assert property (ia_load |=> ia_busy)
      else $error("busy did not follow load");
   chk_read_len: assert property (ia_load && ia_rnw |=>
      ia_busy [*3] ##1 !ia_busy) else $error("read busy length wrong");
   chk_write_len: assert property (id_write |->
      ia_busy [*4] ##1 !ia_busy) else $error("write busy length wrong");
   chk_write_order: assert property (id_write |->
      $past(ia_load) && !ia_rnw) else $error("data strobe out of order");
   chk_count_msb: assert property (cnt_rd |-> ##4 !id_rdata[7])
      else $error("count top bit not zero");
   chk_gap_zero: assert property (gap_rd |-> ##4 id_rdata == 8'h00)
      else $error("unmapped offset read nonzero");
   // Result only moves when an access completes
   chk_rdata_hold: assert property (!$fell(ia_busy) |->
      $stable(id_rdata)) else $error("read result moved while idle");
   cov_read: cover property (ia_load && ia_rnw);
   cov_write: cover property (id_write);
   cov_count: cover property (cnt_rd);
endmodule

/* tb/usb_endpoint_buffers_tb.sv */
// Bench joining controller and endpoint block, driving software and engine.
// Assumes the design files and the interface are compiled first.
`timescale 1ns/1ps
`include "usb_ep_cfg.svh"
module usb_endpoint_buffers_tb
   import usb_ep_pkg::*;
;
   logic mclk = 1'h0, nrst = 1'h0, sw_wr = 1'h0, sw_rd = 1'h0;
   logic rx_start = 1'h0, rx_setup = 1'h0, rx_valid = 1'h0, rx_ok = 1'h0;
   logic rx_err = 1'h0, in_req = 1'h0, in_ack = 1'h0;
   logic rd_chk = 1'h0, rd_chk_d = 1'h0;
   logic [1:0] sw_addr = 2'h0, rx_ep = 2'h0, in_ep = 2'h0;
   logic [7:0] sw_wdata = 8'h00, rx_data = 8'h00, flags, cnt0, su0;
   logic [7:0] sw_rdata, tx_data, mem [64];
   logic hs_ack, hs_nak, tx_valid, tx_eop, usb_irq;
   logic [15:0] seed = 16'h0E11;
   logic [9:0] evq [$];
   logic [7:0] rdq [$];
   int fails = 0, comparisons = 0, n, bp;
   int kbp [4] = '{1, 2, 5, 2};
   logic [4:0] kofs [4] = '{`OFS_DP0, `OFS_DP1, `OFS_DPS, `OFS_DP1};
   always #5 mclk = ~mclk;
   usb_ep_if usb_ep_if_inst ();
   usb_ep_dev usb_ep_dev_inst (.mclk, .nrst, .cpu(usb_ep_if_inst.dev),
      .rx_start, .rx_ep, .rx_setup, .rx_valid, .rx_data, .rx_ok, .rx_err,
      .in_req, .in_ep, .in_ack, .hs_ack, .hs_nak, .tx_valid, .tx_data,
      .tx_eop, .usb_irq);
   usb_ep_ctl usb_ep_ctl_inst (.mclk, .nrst, .usb(usb_ep_if_inst.ctl),
      .sw_addr, .sw_wdata, .sw_wr, .sw_rd, .sw_rdata);
   usb_ep_link_chk usb_ep_link_chk_inst (.mclk, .nrst,
      .ia_load(usb_ep_if_inst.ia_load), .ia_rnw(usb_ep_if_inst.ia_rnw),
      .ia_addr(usb_ep_if_inst.ia_addr), .id_write(usb_ep_if_inst.id_write),
      .id_wdata(usb_ep_if_inst.id_wdata), .id_rdata(usb_ep_if_inst.id_rdata),
      .ia_busy(usb_ep_if_inst.ia_busy));
   task automatic check(input string nm, input logic [9:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [7:0] rnd();
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      return seed[7:0];
   endfunction
   // One software strobe; a checked read notes its result slot
   task automatic sw_op(input logic [1:0] a, input logic [7:0] d,
      input logic wr, chk);
      @(posedge mclk);
      sw_addr <= a; sw_wdata <= d; sw_wr <= wr; sw_rd <= !wr; rd_chk <= chk;
      @(posedge mclk);
      sw_wr <= 1'h0; sw_rd <= 1'h0; rd_chk <= 1'h0;
   endtask
   // Poll status under a bound so a stuck busy cannot hang the run
   task automatic idle();
      for (int i = 0; i < 20; i++) begin
         sw_op(`CTL_STAT, 8'h00, 1'h0, 1'h0);
         @(negedge mclk);
         if (sw_rdata[`STAT_BUSY] === 1'h0) return;
      end
      fails++;
   endtask
   task automatic iwr(input logic [4:0] o, input logic [7:0] v);
      sw_op(`CTL_DATA, v, 1'h1, 1'h0);
      sw_op(`CTL_CMD, {3'h0, o}, 1'h1, 1'h0);
      idle();
   endtask
   task automatic ird(input logic [4:0] o, input logic [7:0] e);
      sw_op(`CTL_CMD, {3'h4, o}, 1'h1, 1'h0);
      idle();
      rdq.push_back(e);
      sw_op(`CTL_RESULT, 8'h00, 1'h0, 1'h1);
   endtask
   task automatic in_tx(input logic [1:0] ep, input logic ack);
      @(posedge mclk);
      in_req <= 1'h1; in_ep <= ep;
      @(posedge mclk);
      in_req <= 1'h0;
      repeat (70) @(posedge mclk);
      in_ack <= ack;
      @(posedge mclk);
      in_ack <= 1'h0;
   endtask
   task automatic rx_pkt(input logic [1:0] ep, input logic st, good);
      @(posedge mclk);
      rx_start <= 1'h1; rx_ep <= ep; rx_setup <= st;
      for (int i = 0; i < n; i++) begin
         @(posedge mclk);
         rx_start <= 1'h0; rx_valid <= 1'h1; rx_data <= mem[i];
      end
      @(posedge mclk);
      rx_start <= 1'h0; rx_valid <= 1'h0; rx_ok <= good; rx_err <= !good;
      @(posedge mclk);
      rx_ok <= 1'h0; rx_err <= 1'h0;
   endtask
   task automatic final_report();
      if (evq.size() != 0 || rdq.size() != 0) fails++;
      if (fails == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Engine answers are 10-bit notes: data, end 100h, ACK 200h, NAK 300h
   always @(posedge mclk) begin
      rd_chk_d <= rd_chk;
      if (rd_chk_d) check("sw_rdata", {2'h0, sw_rdata},
         {2'h0, rdq.size() ? rdq.pop_front() : 8'hXX});
      if (hs_ack | hs_nak | tx_valid | tx_eop) check("engine", tx_valid ?
         {2'h0, tx_data} : {hs_ack | hs_nak, hs_nak | tx_eop, 8'h00},
         evq.size() ? evq.pop_front() : 10'h3FF);
   end
   initial begin
      #300000;
      fails++;
      final_report();
   end
   initial begin
      repeat (3) @(posedge mclk);
      nrst <= 1'h1;
      flags = 8'h19;
      ird(`OFS_FLAGS, flags);
      for (int c = 0; c < 4; c++) ird(`OFS_BC0 + 5'(c), 8'h00);
      evq.push_back(10'h300);
      in_tx(`EP_IN3, 1'h0);
      iwr(`OFS_BC2, 8'h41);
      rdq.push_back(8'h02);
      sw_op(`CTL_STAT, 8'h00, 1'h0, 1'h1);
      // Load and send each IN endpoint, the last one full
      for (int e = 0; e < 4; e++) if (e != 1) begin
         n = (e == 3) ? 64 : int'(rnd() & 8'h3F);
         bp = (e == 0) ? 0 : e + 1;
         for (int i = 0; i < n; i++) mem[i] = rnd();
         for (int i = 0; i < n; i++) iwr(`OFS_DP0 + 5'(e), mem[i]);
         iwr(`OFS_BC0 + 5'(e), 8'(n));
         flags[bp] = 1'h0;
         if (e == 0) cnt0 = 8'(n);
         ird(`OFS_BC0 + 5'(e), 8'(n));
         ird(`OFS_FLAGS, flags);
         for (int i = 0; i < n; i++) evq.push_back({2'h0, mem[i]});
         evq.push_back(10'h100);
         in_tx(2'(e), 1'h1);
         flags[bp] = 1'h1;
         ird(`OFS_FLAGS, flags);
      end
      // A bad packet must leave the endpoint 0 count alone
      iwr(`OFS_IRQ_EN, 8'h06);
      n = 5;
      rx_pkt(`EP_CTRL, 1'h0, 1'h0);
      ird(`OFS_BC0, cnt0);
      // Good OUT0, OUT1, setup, then OUT1 again after its flag is cleared
      for (int k = 0; k < 4; k++) begin
         n = (k == 2) ? 8 : 1 + int'(rnd() & 8'h3F);
         bp = kbp[k];
         for (int i = 0; i < n; i++) mem[i] = rnd();
         if (k == 2) su0 = mem[0];
         evq.push_back(10'h200);
         rx_pkt(2'(k & 1), k == 2, 1'h1);
         flags[bp] = 1'h1;
         ird(`OFS_FLAGS, flags);
         if (k != 2) ird(`OFS_BC0 + 5'(k & 1), 8'(n));
         check("usb_irq", {9'h0, usb_irq}, {9'h0, k != 2});
         for (int i = 0; i < n; i++) ird(kofs[k], mem[i]);
         // Control OUT is refused while its data-available flag is set
         if (k == 0) begin
            evq.push_back(10'h300);
            rx_pkt(`EP_CTRL, 1'h0, 1'h1);
         end
         flags[bp] = 1'h0;
         iwr(`OFS_FLAGS, ~(8'h01 << bp));
         @(negedge mclk);
         check("usb_irq", {9'h0, usb_irq}, 10'h000);
      end
      ird(5'h1F, 8'h00);
      // Second reset mid-run returns counts and flags to their reset state
      @(posedge mclk);
      nrst <= 1'h0;
      repeat (3) @(posedge mclk);
      nrst <= 1'h1;
      ird(`OFS_BC0, 8'h00);
      ird(`OFS_FLAGS, 8'h19);
      ird(`OFS_DPS, su0);
      repeat (3) @(posedge mclk);
      final_report();
   end
endmodule
